// >>> hw/adc_serial_readout.sv
// Purpose: Mode selection, conversion control and serial readout.
// Assumes: Pins are asynchronous; sample_code is on core_clk.
// Notes:   Pin edges seen after two flops; sck far below core_clk.
//
// Function
// - Start rise picks CS or chain mode
// - Data input tied to start gives chain
// - Optional busy start bit precedes result
// - CS busy when start or input low
// - Chain busy when SCK high at start
// - Power down automatically after every conversion
// - 3-wire start tristates the data output
// - Conversion completes regardless of start pin
// - Start fall drives MSB, SCK falls shift
// - Data changes after SCK fall, stable across SCK rise
// - Release after 14th fall or start rise
// - With busy, output tristated during conversion
// - CS busy drives output low at completion, chain busy drives it high
// - Busy release after 15th fall or start
// - 4-wire drives low when both pins low
// - Data input low selects device, MSB out
// - 4-wire release at 14th fall, input rise
`include "adc_readout_defs.svh"
`default_nettype none

module adc_serial_readout
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Link pins
  input  wire logic                 convert_start_pin,
  input  wire logic                 serial_data_input,
  input  wire logic                 serial_clock,
  output logic                      serial_data_output,
  output logic                      serial_data_output_oe,
  // Converter core
  input  wire logic [`RESULT_W-1:0] sample_code,
  // Status
  output logic                      acq_power_down,
  output logic                      conversion_active,
  output logic                      chain_mode,
  output logic                      busy_enabled
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Number of falling edges that complete one frame
  function automatic logic [3:0] frame_bits(input logic busy);
    frame_bits = busy ? `BITS_BUSY : `BITS_NO_BUSY;
  endfunction : frame_bits

  // Frame loaded at completion, start bit ahead when busy is on
  function automatic logic [`FRAME_W-1:0] frame_load(
    input logic                 busy,
    input logic                 start_bit,
    input logic [`RESULT_W-1:0] code
  );
    frame_load = busy ? {start_bit, code} : {code, 1'b0};
  endfunction : frame_load

  // ****************************************************************
  // Pin synchroniser and conversion timer
  // ****************************************************************
  pin_sync_if ps ();

  logic                 conv_done;
  logic [`RESULT_W-1:0] conv_result;
  rd_all_t              r_reg;
  rd_all_t              r_next;

  pin_sync u_sync (
    .core_clk          (core_clk),
    .reset             (reset),
    .convert_start_pin (convert_start_pin),
    .serial_data_input (serial_data_input),
    .serial_clock      (serial_clock),
    .ps                (ps.src)
  );

  conv_timer u_timer (
    .core_clk    (core_clk),
    .reset       (reset),
    .start       (r_reg.start),
    .sample_code (sample_code),
    .done        (conv_done),
    .result      (conv_result)
  );

  // ****************************************************************
  // Readout sequencer
  // ****************************************************************

  // Select is start pin low (3-wire) or data input low (4-wire)
  logic selected;
  logic deselect;
  assign selected = ~ps.start | ~ps.din;
  assign deselect = ps.start_rise | ps.din_rise;

  // Next state of the whole sequencer
  always_comb begin
    r_next       = r_reg;
    r_next.start = 1'b0;
    unique case (r_reg.st)
      // Powered-down acquisition, no result left to read
      ST_ACQ: begin
        if (ps.start_rise) begin
          // Input taken before the edge: a tied input reads low
          r_next.chain      = ~ps.din_prev;
          r_next.chain      = ~ps.din_prev;
          r_next.chain_busy = ps.sck;
          r_next.oe         = 1'b0;
          r_next.start      = 1'b1;
          r_next.st         = ST_CONV;
        end else begin
          // Both low drives a low level, else released
          r_next.oe   = ~ps.start & ~ps.din;
          r_next.dout = 1'b0;
        end
      end
      // Conversion on the internal clock, start edges ignored
      ST_CONV: begin
        r_next.oe = 1'b0;
        if (conv_done) begin
          if (r_reg.chain) begin
            r_next.busy  = r_reg.chain_busy;
            r_next.shreg = frame_load(r_reg.chain_busy, 1'b1,
                                      conv_result);
            r_next.oe    = 1'b1;
            r_next.nbits = '0;
            r_next.st    = ST_SHIFT;
          end else if (selected) begin
            // Busy on: drive the low start bit as interrupt
            r_next.busy  = 1'b1;
            r_next.shreg = frame_load(1'b1, 1'b0, conv_result);
            r_next.oe    = 1'b1;
            r_next.nbits = '0;
            r_next.st    = ST_SHIFT;
          end else begin
            r_next.busy  = 1'b0;
            r_next.shreg = frame_load(1'b0, 1'b0, conv_result);
            r_next.nbits = '0;
            r_next.st    = ST_WAIT_SEL;
          end
        end
      end
      // CS mode without busy: wait for the host to select
      ST_WAIT_SEL: begin
        if (ps.start_rise) begin
          r_next.chain      = ~ps.din_prev;
          r_next.chain_busy = ps.sck;
          r_next.oe         = 1'b0;
          r_next.start      = 1'b1;
          r_next.st         = ST_CONV;
        end else if (selected) begin
          r_next.oe = 1'b1;
          r_next.oe = 1'b1;
          r_next.st = ST_SHIFT;
        end
      end
      // Shift out on SCK falling edges, MSB first
      ST_SHIFT: begin
        if (ps.start_rise) begin
          r_next.chain      = ~ps.din_prev;
          r_next.chain_busy = ps.sck;
          r_next.oe         = 1'b0;
          r_next.start      = 1'b1;
          r_next.st         = ST_CONV;
        end else if (!r_reg.chain && deselect) begin
          r_next.oe = 1'b0;
          r_next.st = ST_ACQ;
        end else if (ps.sck_fall) begin
          // Chain mode passes the data input into the register tail
          r_next.shreg = {r_reg.shreg[`FRAME_W-2:0],
                          r_reg.chain & ps.din};
          r_next.nbits = r_reg.nbits + 1'b1;
          if (!r_reg.chain &&
              r_next.nbits == frame_bits(r_reg.busy)) begin
            r_next.oe = 1'b0;
            r_next.oe = 1'b0;
            r_next.st = ST_ACQ;
          end
        end
      end
    endcase
    // Output bit changes only on an SCK fall or a load
    if (r_next.st == ST_SHIFT) begin
      r_next.dout = r_next.shreg[`FRAME_W-1];
    end
    r_next.conv = (r_next.st == ST_CONV);
    r_next.pd   = (r_next.st != ST_CONV);
  end

  // Register the sequencer state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r_reg    <= '0;
      r_reg.st <= ST_ACQ;
      r_reg.pd <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs, each straight from a flop
  // ****************************************************************
  assign serial_data_output    = r_reg.dout;
  assign serial_data_output_oe = r_reg.oe;
  assign acq_power_down        = r_reg.pd;
  assign conversion_active     = r_reg.conv;
  assign chain_mode            = r_reg.chain;
  assign busy_enabled          = r_reg.busy;

endmodule : adc_serial_readout

`default_nettype wire

// >>> hw/adc_readout_defs.svh
// Purpose: Shared constants of the serial readout block.
// Assumes: Core clock of 40 MHz.
// Notes:   Header holds definitions only.
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_MHZ          40
`define CONV_TIME_NS     1600
// Conversion length rounded up to whole core cycles
`define CONV_CYCLES      ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CONV_CNT_W       7

// ****************************************************************
// Data layout
// ****************************************************************
`define RESULT_W         14
`define FRAME_W          15
`define BITS_NO_BUSY     4'h0E
`define BITS_BUSY        4'h0F

// ****************************************************************
// Pin positions inside the synchroniser vectors
// ****************************************************************
`define PIN_START        0
`define PIN_DIN          1
`define PIN_SCK          2
`define PIN_N            3

`endif

// >>> hw/adc_readout_pkg.sv
// Purpose: Types of the serial readout block.
// Assumes: adc_readout_defs.svh gives the widths.
// Notes:   Each module keeps its whole state in one struct.
`include "adc_readout_defs.svh"
`default_nettype none

package adc_readout_pkg;

  // Readout sequencer states
  typedef enum logic [1:0] {
    ST_ACQ,
    ST_CONV,
    ST_WAIT_SEL,
    ST_SHIFT
  } rd_state_t;

  // Pin synchroniser state
  typedef struct packed {
    logic [`PIN_N-1:0] meta;
    logic [`PIN_N-1:0] live;
    logic [`PIN_N-1:0] prev;
  } sync_state_t;

  // Conversion timer state
  typedef struct packed {
    logic                   run;
    logic                   done;
    logic [`CONV_CNT_W-1:0] cnt;
    logic [`RESULT_W-1:0]   code;
  } timer_state_t;

  // Readout sequencer state
  typedef struct packed {
    rd_state_t            st;
    logic                 chain;
    logic                 chain_busy;
    logic                 busy;
    logic [`FRAME_W-1:0]  shreg;
    logic [3:0]           nbits;
    logic                 dout;
    logic                 oe;
    logic                 pd;
    logic                 conv;
    logic                 start;
  } rd_all_t;

endpackage : adc_readout_pkg

`default_nettype wire

// >>> hw/pin_sync_if.sv
// Purpose: Carries synchronised pin levels and edges.
// Assumes: Driven by pin_sync, read by the sequencer.
// Notes:   All signals on core_clk.
`include "adc_readout_defs.svh"
`default_nettype none

interface pin_sync_if;
  logic start;
  logic din;
  logic sck;
  logic din_prev;
  logic start_rise;
  logic din_rise;
  logic sck_fall;

  modport src (output start, din, sck, din_prev, start_rise, din_rise,
               sck_fall);
  modport dst (input  start, din, sck, din_prev, start_rise, din_rise,
               sck_fall);
endinterface : pin_sync_if

`default_nettype wire

// >>> hw/pin_sync.sv
// Purpose: Two-flop synchroniser and edge finder for the pins.
// Assumes: Pins are asynchronous to core_clk.
// Notes:   Only the live and prev stages feed edge logic.
`include "adc_readout_defs.svh"
`default_nettype none

module pin_sync
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Raw pins
  input  wire logic convert_start_pin,
  input  wire logic serial_data_input,
  input  wire logic serial_clock,
  // Synchronised view
  pin_sync_if.src   ps
);

  sync_state_t r_reg;
  sync_state_t r_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next      = r_reg;
    r_next.meta = {serial_clock, serial_data_input, convert_start_pin};
    r_next.live = r_reg.meta;
    r_next.prev = r_reg.live;
  end

  // Register the state; ones at reset, so a start pin resting high
  // shows no false rising edge once reset lets go
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r_reg <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Levels and edges seen by the sequencer
  assign ps.start      = r_reg.live[`PIN_START];
  assign ps.din        = r_reg.live[`PIN_DIN];
  assign ps.sck        = r_reg.live[`PIN_SCK];
  assign ps.din_prev   = r_reg.prev[`PIN_DIN];
  assign ps.start_rise = r_reg.live[`PIN_START] & ~r_reg.prev[`PIN_START];
  assign ps.din_rise   = r_reg.live[`PIN_DIN] & ~r_reg.prev[`PIN_DIN];
  assign ps.sck_fall   = ~r_reg.live[`PIN_SCK] & r_reg.prev[`PIN_SCK];

endmodule : pin_sync

`default_nettype wire

// >>> hw/conv_timer.sv
// Purpose: Internal conversion clock count and result capture.
// Assumes: start is a one-cycle pulse on core_clk.
// Notes:   Ignores start while a conversion runs.
`include "adc_readout_defs.svh"
`default_nettype none

module conv_timer
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Control
  input  wire logic                 start,
  input  wire logic [`RESULT_W-1:0] sample_code,
  // Status
  output logic                      done,
  output logic [`RESULT_W-1:0]      result
);

  timer_state_t r_reg;
  timer_state_t r_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (r_reg.run) begin
      if (r_reg.cnt == `CONV_CNT_W'(`CONV_CYCLES - 1)) begin
        r_next.run  = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end else if (start) begin
      r_next.run  = 1'b1;
      r_next.cnt  = '0;
      r_next.code = sample_code;   // Held sample converts to code
    end
  end

  // Register the state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done   = r_reg.done;
  assign result = r_reg.code;

endmodule : conv_timer

`default_nettype wire

// >>> verif/adc_readout_chk.sv
// Purpose: Port assertions of the serial readout block.
// Assumes: One core_clk domain, reset active high.
// Notes:   Bound to adc_serial_readout at the foot.
`default_nettype none

module adc_readout_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pins
  input wire logic convert_start_pin,
  input wire logic serial_data_input,
  input wire logic serial_clock,
  input wire logic serial_data_output,
  input wire logic serial_data_output_oe,
  // Status
  input wire logic acq_power_down,
  input wire logic conversion_active,
  input wire logic chain_mode,
  input wire logic busy_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [7:0] run_reg;
  logic [7:0] run_next;

  // ****************
  // Checks
  // ****************
  // Counts the cycles of the running conversion
  always_comb run_next = conversion_active ? run_reg + 8'h01 : 8'h00;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) run_reg <= 8'h00;
    else run_reg <= run_next;
  end
  pd_idle_a: assert property (acq_power_down != conversion_active)
    else $error("power down not inverse of conversion");
  conv_len_a: assert property ($fell(conversion_active) |->
    run_reg >= 8'h3e && run_reg <= 8'h44) else $error("bad conv length");
  oe_conv_a: assert property (conversion_active |->
    !serial_data_output_oe) else $error("output driven in conversion");
  busy_low_a: assert property ($fell(conversion_active) && !chain_mode
    && busy_enabled |-> serial_data_output_oe && !serial_data_output)
    else $error("no low busy bit");
  chain_high_a: assert property ($fell(conversion_active) && chain_mode
    |-> serial_data_output_oe && (serial_data_output || !busy_enabled))
    else $error("chain output wrong at done");
  sdo_hold_a: assert property (serial_clock[*5] ##0
    ($past(serial_data_output_oe) && serial_data_output_oe)
    |-> $stable(serial_data_output)) else $error("data moved, clock high");
  rise_rel_a: assert property ($rose(convert_start_pin) |->
    ##[1:5] !serial_data_output_oe) else $error("no release on start");
  sdi_rel_a: assert property (!chain_mode && !conversion_active &&
    $rose(serial_data_input) |-> ##[1:5] !serial_data_output_oe)
    else $error("no release on input rise");
  mode_hold_a: assert property ($changed(chain_mode) |->
    ##[0:3] conversion_active) else $error("mode changed outside start");
  cover property ($fell(conversion_active) && busy_enabled);
  cover property ($fell(conversion_active) && chain_mode);
  cover property ($fell(serial_data_output_oe) && !conversion_active);
endmodule : adc_readout_chk

bind adc_serial_readout adc_readout_chk chk (
  .core_clk(core_clk), .reset(reset),
  .convert_start_pin(convert_start_pin),
  .serial_data_input(serial_data_input), .serial_clock(serial_clock),
  .serial_data_output(serial_data_output),
  .serial_data_output_oe(serial_data_output_oe),
  .acq_power_down(acq_power_down), .conversion_active(conversion_active),
  .chain_mode(chain_mode), .busy_enabled(busy_enabled));

`default_nettype wire

// >>> verif/adc_host_model.sv
// Purpose: Host model driving the link pins of the readout block.
// Assumes: Serial clock period of 200 ns, eight core cycles.
// Notes:   Released data line floats to its pull-up.
`default_nettype none

module adc_host_model (
  // Clock
  input  wire logic core_clk,
  // Pins
  input  wire logic dout,
  input  wire logic dout_oe,
  output logic      conv_pin,
  output logic      din,
  output logic      sck
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Host side
  // ****************
  // Level seen on the shared data line
  wire logic line = dout_oe ? dout : 1'b1;
  initial begin
    conv_pin = 1'b0;
    din = 1'b0;
    sck = 1'b0;
  end
  // Clocks out n bits, each sampled while SCK is low, before its rising edge
  task automatic rd(input int n, output logic [14:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge core_clk);
      v = {v[13:0], line};
      sck = 1'b1;
      repeat (4) @(negedge core_clk);
      sck = 1'b0;
    end
    repeat (5) @(negedge core_clk);
  endtask : rd
endmodule : adc_host_model

`default_nettype wire

// >>> verif/adc_serial_readout_modes_test.sv
// Purpose: Self-checking bench of the serial readout block.
// Assumes: Pins driven at falling core_clk edges.
// Notes:   Host model supplies the link side.
`include "adc_readout_defs.svh"
`default_nettype none

module adc_serial_readout_modes_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk = 1'b0;
  logic                 reset = 1'b1;
  logic [`RESULT_W-1:0] code = 14'h2a5c;
  logic [14:0]          v;
  int                   n_mismatch = 0;
  int                   checked = 0;
  int                   cyc_cnt = 0;
  wire logic            dout, oe, pd, ca, chm, bsy, conv_pin, din, sck;

  adc_serial_readout dut (.core_clk(core_clk), .reset(reset),
    .convert_start_pin(conv_pin), .serial_data_input(din),
    .serial_clock(sck), .serial_data_output(dout),
    .serial_data_output_oe(oe), .sample_code(code),
    .acq_power_down(pd), .conversion_active(ca),
    .chain_mode(chm), .busy_enabled(bsy));
  adc_host_model host (.core_clk(core_clk), .dout(dout), .dout_oe(oe),
    .conv_pin(conv_pin), .din(din), .sck(sck));

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [14:0] s, e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // Starts a conversion with the given input and clock levels
  task automatic go(input logic d, k, tie);
    host.conv_pin = 1'b0;
    host.din = d;
    host.sck = k;
    cyc(4);
    host.conv_pin = 1'b1;
    if (tie) host.din = 1'b1;
    cyc(2);
    host.sck = 1'b0;
    cyc(4);
    chk("start", 15'({oe, ca, pd}), 15'h2);
  endtask : go
  task automatic wait_done;
    for (int i = 0; i < 100 && ca; i++) cyc(1);
    chk("done", 15'({ca, pd}), 15'h1);
  endtask : wait_done
  task automatic t_chain;
    chk("idle_low", 15'({oe, host.line}), 15'h2);
    go(0, 0, 1);
    chk("mode", 15'({chm, bsy}), 15'h2);
    wait_done;
    chk("msb", 15'({oe, host.line}), 15'({1'b1, code[13]}));
    host.rd(14, v);
    chk("chain_data", v, 15'(code));
    code = 14'h1337;
    go(0, 1, 0);
    chk("mode_busy", 15'({chm, bsy}), 15'h2);
    wait_done;
    chk("busy_high", 15'({bsy, oe, host.line}), 15'h7);
    host.rd(15, v);
    chk("chain_busy", v, {1'b1, code});
  endtask : t_chain
  task automatic t_cs3;
    code = 14'h35a5;
    go(1, 0, 0);
    cyc(2);
    host.conv_pin = 1'b0;
    cyc(4);
    host.conv_pin = 1'b1;
    wait_done;
    chk("cs_quiet", 15'({chm, bsy, oe}), 15'h0);
    host.conv_pin = 1'b0;
    host.rd(14, v);
    chk("cs_data", v, 15'(code));
    chk("cs_rel", 15'(oe), 15'h0);
  endtask : t_cs3
  task automatic t_cs3b;
    code = 14'h0c3a;
    go(1, 0, 0);
    host.conv_pin = 1'b0;
    wait_done;
    chk("busy_low", 15'({bsy, oe, host.line}), 15'h6);
    host.rd(15, v);
    chk("cs_busy", v, 15'(code));
    chk("busy_rel", 15'(oe), 15'h0);
  endtask : t_cs3b
  task automatic t_cs4;
    code = 14'h2001;
    go(1, 0, 0);
    host.din = 1'b0;
    cyc(3);
    host.din = 1'b1;
    wait_done;
    chk("sel_wait", 15'({bsy, oe}), 15'h0);
    host.din = 1'b0;
    host.rd(5, v);
    chk("sel_data", v, 15'(code[13:9]));
    host.din = 1'b1;
    cyc(5);
    chk("sdi_rel", 15'(oe), 15'h0);
  endtask : t_cs4
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ****************
  // Run
  // ****************
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Cuts a hung run short
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    cyc(5);
    chk("reset", 15'({pd, ca, chm, bsy, oe}), 15'h10);
    reset = 1'b0;
    cyc(5);
    t_chain;
    t_cs3;
    t_cs3b;
    t_cs4;
    stop_test();
  end
endmodule : adc_serial_readout_modes_test

`default_nettype wire
